//--- design/lrm_pkg.sv
`default_nettype none
package lrm_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int POR_TIME_MS = 12;
    localparam int POR_CYCLES = (POR_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int RST_TIME_NS = 3000;
    localparam int RST_CYCLES = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // internal clock tick, one every eight system cycles
    localparam logic [2:0] TICK_LAST = 3'h7;

    // command bytes (C/D = 0, W/R = 0)
    localparam logic [7:0] CMD_SYS_RESET = 8'he2;
    localparam logic [7:0] CMD_DISP_MASK = 8'hfe;
    localparam logic [7:0] CMD_DISP_VAL = 8'hae;
    localparam logic [7:0] CMD_PWR_MASK = 8'hf8;
    localparam logic [7:0] CMD_PWR_VAL = 8'h28;
    localparam logic [7:0] CMD_GAIN_MASK = 8'hf8;
    localparam logic [7:0] CMD_GAIN_VAL = 8'h20;
    localparam logic [7:0] CMD_BIAS_MASK = 8'hfc;
    localparam logic [7:0] CMD_BIAS_VAL = 8'he8;
    localparam int DISP_EN_POS = 0;

    // register defaults
    localparam logic DISP_EN_RST = 1'b0;
    localparam logic [2:0] PWR_RST = 3'h0;
    localparam logic [2:0] GAIN_RST = 3'h0;
    localparam logic [1:0] BIAS_RST = 2'h0;
    localparam int CFG_W = 2;

    // status byte layout
    localparam int ST_BUSY_POS = 7;
    localparam int ST_RS_POS = 6;
    localparam int ST_MODE_POS = 4;

    typedef enum logic [1:0] {
        MODE_RESET = 2'b00,
        MODE_SLEEP = 2'b10,
        MODE_NORMAL = 2'b11
    } lrm_mode_e;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_POR = 2'b01,
        SEQ_RUN = 2'b10
    } lrm_seq_e;
endpackage
`default_nettype wire

//--- design/lrm_rst_if.sv
`default_nettype none
interface lrm_rst_if;
    logic swReq;
    logic pinLow;
    logic resetRun;
    modport seq (input swReq, input pinLow, output resetRun);
    modport core (output swReq, output pinLow, input resetRun);
endinterface
`default_nettype wire

//--- design/lrm_sync.sv
`default_nettype none
module lrm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1;
            logic stage2;
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else if (clkEn) begin
                    stage1 <= asyncIn[i];
                    stage2 <= stage1;
                end
            end
            assign syncOut[i] = stage2;
        end
    endgenerate
endmodule
`default_nettype wire

//--- design/lrm_reset_seq.sv
`default_nettype none
module lrm_reset_seq #(
    parameter int POR_CYCLES = lrm_pkg::POR_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clkEn,
    lrm_rst_if.seq rif
);
    lrm_pkg::lrm_seq_e state;
    lrm_pkg::lrm_seq_e next_state;
    logic [31:0] cnt;
    logic [31:0] next_cnt;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            lrm_pkg::SEQ_POR: begin
                // supply settle wait, then the system reset proper
                if (cnt == 32'(POR_CYCLES - 1)) begin
                    next_state = lrm_pkg::SEQ_RUN;
                    next_cnt = 32'h0;
                end else begin
                    next_cnt = cnt + 32'h1;
                end
            end
            lrm_pkg::SEQ_RUN: begin
                if (rif.swReq || rif.pinLow) begin
                    next_cnt = 32'h0;
                end else if (cnt == 32'(lrm_pkg::RST_CYCLES - 1)) begin
                    next_state = lrm_pkg::SEQ_IDLE;
                    next_cnt = 32'h0;
                end else begin
                    next_cnt = cnt + 32'h1;
                end
            end
            lrm_pkg::SEQ_IDLE: begin
                if (rif.swReq || rif.pinLow) begin
                    next_state = lrm_pkg::SEQ_RUN;
                    next_cnt = 32'h0;
                end
            end
            default: begin
                next_state = lrm_pkg::SEQ_POR;
                next_cnt = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= lrm_pkg::SEQ_POR;
            cnt <= 32'h0;
        end else if (clkEn) begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    assign rif.resetRun = (state != lrm_pkg::SEQ_IDLE);

    a_por_trigger: assert property (@(posedge clk) disable iff (!rstn)
        (state == lrm_pkg::SEQ_POR) && (cnt == 32'(POR_CYCLES - 1)) && clkEn
        |=> state == lrm_pkg::SEQ_RUN)
        else $error("power-on wait did not start system reset");

    a_source_reset: assert property (@(posedge clk) disable iff (!rstn)
        (rif.swReq || rif.pinLow) && clkEn |=> rif.resetRun && (cnt == 32'h0))
        else $error("reset source did not restart reset run");

    a_reset_length: assert property (@(posedge clk) disable iff (!rstn)
        $fell(rif.resetRun) |-> $past(cnt) == 32'(lrm_pkg::RST_CYCLES - 1))
        else $error("reset run ended with wrong length");
endmodule
`default_nettype wire

//--- design/lrm_reset_mode_ctrl.sv
`default_nettype none
// Contract
// - after core power-up wait about 12 ms, then start system reset automatically
// - reset command or low reset pin also starts system reset
// - reset loads defaults; pin-configured registers reload from configuration pins
// - two-bit mode field: Reset 00, Sleep 10, Normal 11
// - reset-in-progress and busy flags stay one for the 3-5 us reset
// - while resetting only status read executes; other commands dropped
// - Normal runs clock, drivers, pump; Sleep all off; Reset only draining on
// - display enable command sets mode Normal when on, Sleep when off
// - only display enable and reset sources change mode; resets force 00
// - Sleep keeps capacitor charge; draining only in Reset mode
// - mode transitions take effect on internal clock edges only
// - drivers stay off after Sleep or Reset until voltages report ready
// - commands accepted back to back with no extra waits
// - each cycle carries command/data type and direction, 0 write 1 read
module lrm_reset_mode_ctrl #(
    parameter int POR_CYCLES = lrm_pkg::POR_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic resetPinN,
    input wire logic [lrm_pkg::CFG_W-1:0] cfgPins,
    input wire logic vlcdReady,
    input wire logic biasReady,
    input wire logic cmdValid,
    input wire logic cmdIsData,
    input wire logic cmdRead,
    input wire logic [7:0] cmdByte,
    output logic statusValid,
    output logic [7:0] statusByte,
    output logic ramWriteValid,
    output logic [7:0] ramWriteData,
    output logic [1:0] operatingMode,
    output logic resetInProgress,
    output logic busy,
    output logic clockRun,
    output logic driversOn,
    output logic pumpOn,
    output logic drainOn,
    output logic displayEnable,
    output logic [2:0] powerCtrl,
    output logic [2:0] gainCtrl,
    output logic [1:0] biasRatio,
    output logic [lrm_pkg::CFG_W-1:0] pinCfg
);
    localparam int SYNC_W = lrm_pkg::CFG_W + 3;

    lrm_rst_if rif ();

    logic [SYNC_W-1:0] syncVec;
    logic [lrm_pkg::CFG_W-1:0] cfgSync;
    logic pinLowSync;
    logic readyOk;

    // pins and analog ready levels come from outside the clock domain; the reset pin
    // goes in inverted so the cleared synchroniser reads as released, not as a reset
    lrm_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .asyncIn({!resetPinN, vlcdReady, biasReady, cfgPins}),
        .syncOut(syncVec)
    );

    assign cfgSync = syncVec[lrm_pkg::CFG_W-1:0];
    assign readyOk = syncVec[lrm_pkg::CFG_W] && syncVec[lrm_pkg::CFG_W+1];
    assign pinLowSync = syncVec[lrm_pkg::CFG_W+2];

    lrm_reset_seq #(
        .POR_CYCLES(POR_CYCLES)
    ) u_seq (
        .clk(clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .rif(rif)
    );

    // command decode
    logic accept;
    logic statusRead;
    logic ctrlWrite;
    logic dataWrite;
    logic sysResetCmd;
    logic dispCmd;

    assign resetInProgress = rif.resetRun;
    assign busy = rif.resetRun;
    assign accept = cmdValid && clkEn;
    assign statusRead = accept && !cmdIsData && cmdRead;
    // everything but the status read is dropped while a reset runs
    assign ctrlWrite = accept && !cmdIsData && !cmdRead && !resetInProgress;
    assign dataWrite = accept && cmdIsData && !cmdRead && !resetInProgress;
    assign sysResetCmd = ctrlWrite && (cmdByte == lrm_pkg::CMD_SYS_RESET);
    assign dispCmd = ctrlWrite && ((cmdByte & lrm_pkg::CMD_DISP_MASK) == lrm_pkg::CMD_DISP_VAL);

    assign rif.swReq = sysResetCmd;
    assign rif.pinLow = pinLowSync;

    // internal clock tick
    logic [2:0] divCnt;
    logic [2:0] next_divCnt;
    logic tickNow;

    assign tickNow = clkEn && (divCnt == lrm_pkg::TICK_LAST);

    always_comb begin
        next_divCnt = divCnt + 3'h1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCnt <= 3'h0;
        end else if (clkEn) begin
            divCnt <= next_divCnt;
        end
    end

    // control registers and the requested mode
    lrm_pkg::lrm_mode_e modeReq;
    lrm_pkg::lrm_mode_e next_modeReq;
    logic next_displayEnable;
    logic [2:0] next_powerCtrl;
    logic [2:0] next_gainCtrl;
    logic [1:0] next_biasRatio;
    logic [lrm_pkg::CFG_W-1:0] next_pinCfg;

    always_comb begin
        next_modeReq = modeReq;
        next_displayEnable = displayEnable;
        next_powerCtrl = powerCtrl;
        next_gainCtrl = gainCtrl;
        next_biasRatio = biasRatio;
        next_pinCfg = pinCfg;
        if (resetInProgress) begin
            next_modeReq = lrm_pkg::MODE_RESET;
            next_displayEnable = lrm_pkg::DISP_EN_RST;
            next_powerCtrl = lrm_pkg::PWR_RST;
            next_gainCtrl = lrm_pkg::GAIN_RST;
            next_biasRatio = lrm_pkg::BIAS_RST;
            next_pinCfg = cfgSync;
        end else if (dispCmd) begin
            next_displayEnable = cmdByte[lrm_pkg::DISP_EN_POS];
            next_modeReq = cmdByte[lrm_pkg::DISP_EN_POS] ? lrm_pkg::MODE_NORMAL
                                                         : lrm_pkg::MODE_SLEEP;
        end else if (ctrlWrite) begin
            // each write stands alone, so commands may follow every cycle
            if ((cmdByte & lrm_pkg::CMD_PWR_MASK) == lrm_pkg::CMD_PWR_VAL) begin
                next_powerCtrl = cmdByte[2:0];
            end
            if ((cmdByte & lrm_pkg::CMD_GAIN_MASK) == lrm_pkg::CMD_GAIN_VAL) begin
                next_gainCtrl = cmdByte[2:0];
            end
            if ((cmdByte & lrm_pkg::CMD_BIAS_MASK) == lrm_pkg::CMD_BIAS_VAL) begin
                next_biasRatio = cmdByte[1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            modeReq <= lrm_pkg::MODE_RESET;
            displayEnable <= lrm_pkg::DISP_EN_RST;
            powerCtrl <= lrm_pkg::PWR_RST;
            gainCtrl <= lrm_pkg::GAIN_RST;
            biasRatio <= lrm_pkg::BIAS_RST;
            pinCfg <= '0;
        end else if (clkEn) begin
            modeReq <= next_modeReq;
            displayEnable <= next_displayEnable;
            powerCtrl <= next_powerCtrl;
            gainCtrl <= next_gainCtrl;
            biasRatio <= next_biasRatio;
            pinCfg <= next_pinCfg;
        end
    end

    // applied mode and driver release
    lrm_pkg::lrm_mode_e modeCur;
    lrm_pkg::lrm_mode_e next_modeCur;
    logic driversReleased;
    logic next_driversReleased;

    always_comb begin
        next_modeCur = modeCur;
        next_driversReleased = driversReleased;
        // the request waits for the internal clock edge, so a burst of
        // display enable commands settles on the last one
        if (tickNow) begin
            next_modeCur = modeReq;
        end
        if (modeCur != lrm_pkg::MODE_NORMAL) begin
            next_driversReleased = 1'b0;
        end else if (readyOk) begin
            next_driversReleased = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            modeCur <= lrm_pkg::MODE_RESET;
            driversReleased <= 1'b0;
        end else if (clkEn) begin
            modeCur <= next_modeCur;
            driversReleased <= next_driversReleased;
        end
    end

    assign operatingMode = modeCur;
    assign clockRun = (modeCur == lrm_pkg::MODE_NORMAL);
    assign pumpOn = (modeCur == lrm_pkg::MODE_NORMAL);
    assign driversOn = (modeCur == lrm_pkg::MODE_NORMAL) && driversReleased;
    // sleep keeps the external charge for a fast wake-up
    assign drainOn = (modeCur == lrm_pkg::MODE_RESET);

    // host answers
    localparam int ST_BUSY = lrm_pkg::ST_BUSY_POS;
    localparam int ST_RS = lrm_pkg::ST_RS_POS;
    localparam int ST_MODE = lrm_pkg::ST_MODE_POS;
    logic next_statusValid;
    logic [7:0] next_statusByte;
    logic next_ramWriteValid;
    logic [7:0] next_ramWriteData;

    always_comb begin
        next_statusValid = statusRead;
        next_statusByte = statusByte;
        next_ramWriteValid = dataWrite;
        next_ramWriteData = ramWriteData;
        if (statusRead) begin
            next_statusByte = 8'h00;
            next_statusByte[ST_BUSY] = busy;
            next_statusByte[ST_RS] = resetInProgress;
            next_statusByte[ST_MODE+:2] = modeCur;
        end
        if (dataWrite) begin
            next_ramWriteData = cmdByte;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            statusValid <= 1'b0;
            statusByte <= 8'h00;
            ramWriteValid <= 1'b0;
            ramWriteData <= 8'h00;
        end else if (clkEn) begin
            statusValid <= next_statusValid;
            statusByte <= next_statusByte;
            ramWriteValid <= next_ramWriteValid;
            ramWriteData <= next_ramWriteData;
        end
    end

    a_defaults_reload: assert property (@(posedge clk) disable iff (!rstn)
        resetInProgress && clkEn |=> (powerCtrl == lrm_pkg::PWR_RST)
            && (gainCtrl == lrm_pkg::GAIN_RST) && !displayEnable
            && (pinCfg == $past(cfgSync)))
        else $error("registers not reloaded during reset");

    a_mode_encoding: assert property (@(posedge clk) disable iff (!rstn)
        operatingMode == 2'b00 || operatingMode == 2'b10 || operatingMode == 2'b11)
        else $error("illegal operating mode code");

    a_flags_together: assert property (@(posedge clk) disable iff (!rstn)
        busy == resetInProgress)
        else $error("busy and reset flags differ");

    a_drop_during_reset: assert property (@(posedge clk) disable iff (!rstn)
        accept && !cmdRead && resetInProgress |=> !ramWriteValid
            && (modeReq == lrm_pkg::MODE_RESET))
        else $error("command executed during reset");

    a_mode_outputs: assert property (@(posedge clk) disable iff (!rstn)
        (operatingMode == 2'b10) |-> !clockRun && !pumpOn && !driversOn && !drainOn)
        else $error("sleep mode outputs wrong");

    a_display_on: assert property (@(posedge clk) disable iff (!rstn || !clkEn)
        ctrlWrite && (cmdByte == 8'haf) |-> ##[1:10]
            (operatingMode == 2'b11 || resetInProgress))
        else $error("display on did not reach normal mode");

    a_reset_mode: assert property (@(posedge clk) disable iff (!rstn)
        resetInProgress && $past(resetInProgress) && tickNow |=> operatingMode == 2'b00)
        else $error("reset did not force mode 00");

    a_drain_reset: assert property (@(posedge clk) disable iff (!rstn)
        drainOn |-> operatingMode == 2'b00 && !pumpOn)
        else $error("draining outside reset mode");

    a_mode_on_tick: assert property (@(posedge clk) disable iff (!rstn)
        $changed(operatingMode) |-> $past(tickNow))
        else $error("mode changed off the internal clock edge");

    a_drivers_ready: assert property (@(posedge clk) disable iff (!rstn)
        $rose(driversOn) |-> $past(readyOk) || $past(driversReleased))
        else $error("drivers released before voltages ready");

    a_status_answer: assert property (@(posedge clk) disable iff (!rstn)
        statusRead |=> statusValid && (statusByte[ST_BUSY] == $past(busy))
            && (statusByte[ST_MODE+:2] == $past(operatingMode)))
        else $error("status read answer wrong");
endmodule
`default_nettype wire

//--- test/lrm_host_model.sv
`default_nettype none
module lrm_host_model (
    input wire logic clk,
    output logic cmdValid,
    output logic cmdIsData,
    output logic cmdRead,
    output logic [7:0] cmdByte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] lastByte;
    initial begin
        cmdValid = 1'b0;
        cmdIsData = 1'b0;
        cmdRead = 1'b0;
        lastByte = 8'h00;
        cmdByte = 8'hff;
    end
    // caller sits just after a rising edge; the cycle is taken at the next one
    task automatic xfer(input logic isData, input logic rd, input logic [7:0] b);
        cmdValid = 1'b1;
        cmdIsData = isData;
        cmdRead = rd;
        cmdByte = b;
        lastByte = b;
        @(posedge clk);
        #5;
    endtask
    // a released bus shows the inverse of the last byte, never a stale copy
    task automatic idle();
        cmdValid = 1'b0;
        cmdByte = ~lastByte;
    endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int POR = 16;
    localparam int RUN = lrm_pkg::RST_CYCLES;
    localparam int LIMIT = 3000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic clkEn = 1'b1;
    logic resetPinN = 1'b1;
    logic [lrm_pkg::CFG_W-1:0] cfgPins = 2'h2;
    logic vlcdReady = 1'b1;
    logic biasReady = 1'b1;
    logic cmdValid, cmdIsData, cmdRead, statusValid, ramWriteValid;
    logic [7:0] cmdByte, statusByte, ramWriteData;
    logic [1:0] operatingMode, biasRatio;
    logic resetInProgress, busy, clockRun, driversOn, pumpOn, drainOn, displayEnable;
    logic [2:0] powerCtrl, gainCtrl;
    logic [lrm_pkg::CFG_W-1:0] pinCfg;
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    lrm_host_model host_u (.clk(clk), .cmdValid(cmdValid), .cmdIsData(cmdIsData),
        .cmdRead(cmdRead), .cmdByte(cmdByte));

    lrm_reset_mode_ctrl #(.POR_CYCLES(POR)) dut_u (.clk(clk), .rstn(rstn), .clkEn(clkEn),
        .resetPinN(resetPinN), .cfgPins(cfgPins), .vlcdReady(vlcdReady),
        .biasReady(biasReady), .cmdValid(cmdValid), .cmdIsData(cmdIsData),
        .cmdRead(cmdRead), .cmdByte(cmdByte), .statusValid(statusValid),
        .statusByte(statusByte), .ramWriteValid(ramWriteValid), .ramWriteData(ramWriteData),
        .operatingMode(operatingMode), .resetInProgress(resetInProgress), .busy(busy),
        .clockRun(clockRun), .driversOn(driversOn), .pumpOn(pumpOn), .drainOn(drainOn),
        .displayEnable(displayEnable), .powerCtrl(powerCtrl), .gainCtrl(gainCtrl),
        .biasRatio(biasRatio), .pinCfg(pinCfg));

    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge clk);
            #5;
        end
    endtask

    task automatic wr(input logic [7:0] b);
        host_u.xfer(1'b0, 1'b0, b);
        host_u.idle();
    endtask

    task automatic rd(output logic [7:0] s, output logic v);
        host_u.xfer(1'b0, 1'b1, 8'h00);
        v = statusValid;
        s = statusByte;
        host_u.idle();
    endtask

    task automatic waitRip(input int lim);
        int k;
        k = 0;
        while (resetInProgress !== 1'b0 && k < lim) begin
            cyc(1);
            k++;
        end
    endtask

    // host waits for the mode to settle before relying on it
    task automatic waitMode(input logic [1:0] m, output int k);
        k = 0;
        while (operatingMode !== m && k < 12) begin
            cyc(1);
            k++;
        end
    endtask

    initial begin
        int n;
        int t1;
        int rel;
        logic [7:0] s;
        logic v;
        repeat (16) @(posedge clk);
        #5;
        chk("mode in reset", 8'(operatingMode), 8'h00);
        chk("flags in reset", 8'({busy, resetInProgress}), 8'h03);
        chk("outputs in reset", 8'({drainOn, clockRun, pumpOn, driversOn}), 8'h08);
        rstn = 1'b1;
        rel = cycles;
        cyc(2);
        rd(s, v);
        chk("status valid", 8'(v), 8'h01);
        chk("status in reset", s, 8'hc0);
        host_u.xfer(1'b0, 1'b0, 8'haf);
        host_u.xfer(1'b1, 1'b0, 8'h5a);
        host_u.idle();
        chk("data write in reset", 8'(ramWriteValid), 8'h00);
        waitRip(200);
        n = cycles - rel;
        chk("power-on length", 8'(n >= POR + RUN - 1 && n <= POR + RUN + 2), 8'h01);
        chk("flags after", 8'({busy, resetInProgress}), 8'h00);
        chk("enable dropped", 8'({displayEnable, operatingMode}), 8'h00);
        chk("pin config", 8'(pinCfg), 8'h02);
        $display("test power-on done");

        host_u.xfer(1'b0, 1'b0, 8'h2d);
        host_u.xfer(1'b0, 1'b0, 8'h23);
        host_u.xfer(1'b0, 1'b0, 8'hea);
        host_u.xfer(1'b1, 1'b0, 8'h5a);
        host_u.idle();
        chk("data write", 8'({ramWriteValid, ramWriteData == 8'h5a}), 8'h03);
        chk("control fields", {powerCtrl, gainCtrl, biasRatio}, 8'hae);
        chk("mode unchanged", 8'(operatingMode), 8'h00);
        $display("test back-to-back done");

        wr(8'haf);
        waitMode(2'b11, n);
        t1 = cycles;
        chk("normal reached", 8'(n < 12), 8'h01);
        chk("normal outputs", 8'({clockRun, pumpOn, drainOn}), 8'h06);
        cyc(2);
        chk("drivers on", 8'(driversOn), 8'h01);
        rd(s, v);
        chk("status normal", s, 8'h30);
        vlcdReady = 1'b0;
        cyc(3);
        wr(8'hae);
        waitMode(2'b10, n);
        chk("tick aligned", 8'((cycles - t1) % 8 == 0 && n < 12), 8'h01);
        chk("sleep outputs", 8'({clockRun, pumpOn, drainOn, driversOn}), 8'h00);
        wr(8'haf);
        waitMode(2'b11, n);
        cyc(6);
        chk("drivers held", 8'(driversOn), 8'h00);
        vlcdReady = 1'b1;
        n = 0;
        while (driversOn !== 1'b1 && n < 8) begin
            cyc(1);
            n++;
        end
        chk("drivers released", 8'(driversOn), 8'h01);
        $display("test modes done");

        cfgPins = 2'h1;
        wr(8'he2);
        rel = cycles;
        chk("command reset flags", 8'({busy, resetInProgress}), 8'h03);
        cyc(1);
        chk("defaults", {powerCtrl, gainCtrl, biasRatio}, 8'h00);
        chk("enable default", 8'(displayEnable), 8'h00);
        wr(8'he2);
        waitRip(100);
        n = cycles - rel;
        chk("reset length", 8'(n == RUN), 8'h01);
        chk("reset mode", 8'({operatingMode, drainOn, clockRun}), 8'h02);
        chk("pin reload", 8'(pinCfg), 8'h01);
        $display("test command reset done");

        wr(8'haf);
        waitMode(2'b11, n);
        resetPinN = 1'b0;
        cyc(4);
        chk("pin reset flags", 8'(resetInProgress), 8'h01);
        cyc(100);
        chk("pin held", 8'({resetInProgress, operatingMode, drainOn}), 8'h09);
        resetPinN = 1'b1;
        rel = cycles;
        waitRip(100);
        n = cycles - rel;
        chk("pin release length", 8'(n >= RUN && n <= RUN + 5), 8'h01);
        $display("test reset pin done");

        clkEn = 1'b0;
        wr(8'haf);
        cyc(16);
        chk("frozen mode", 8'({displayEnable, operatingMode}), 8'h00);
        clkEn = 1'b1;
        cyc(16);
        chk("frozen command lost", 8'({displayEnable, operatingMode}), 8'h00);
        $display("test clock enable done");
        end_of_test();
    end
endmodule
`default_nettype wire
